// ### rtl/usb_test_defs.svh
`ifndef USB_TEST_DEFS_SVH
`define USB_TEST_DEFS_SVH

// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define OFF_GLOBAL_CTRL 8'h00
`define OFF_TEST_SELECT 8'h04
`define OFF_EP0_CSR 8'h08
`define OFF_DEV_CTRL 8'h0C
`define OFF_EP0_FIFO 8'h10
`define OFF_EP0_COUNT 8'h14
`define OFF_IRQ_STATUS 8'h18
`define OFF_IRQ_MASK 8'h1C

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define BIT_SOFT_RESET 0
`define BIT_TEST_PACKET 3
`define BIT_HS_OVERRIDE 4
`define BIT_FS_OVERRIDE 5
`define BIT_FIFO_ACCESS 6
`define BIT_FORCE_HOST 7
`define BIT_RX_READY 0
`define BIT_TX_READY 1
`define BIT_RX_SERVICED 6
`define BIT_SESSION 0
`define BIT_HOST_MODE 2
`define BIT_B_ROLE 7
`define IRQ_EP0 0
`define IRQ_PKT_SENT 1

// --------------------------------------------------------------
// Sizes, codes and reset values
// --------------------------------------------------------------
`define EP0_DEPTH 64
`define EP0_AW 6
`define PTR_W 7
`define IRQ_W 2
`define PID_DATA0 8'hC3
`define CRC_INIT 16'hFFFF
`define CRC_POLY_REFL 16'hA001
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SPEED_HS 2'h2
`define SPEED_FS 2'h1
`define SPEED_LS 2'h0

`endif

// ### rtl/usb_test_pkg.sv
package usb_test_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PID = 3'b001,
    TX_DATA = 3'b010,
    TX_CRC_LO = 3'b011,
    TX_CRC_HI = 3'b100
  } tx_state_t;

endpackage : usb_test_pkg

// ### rtl/ep0_shared_ram.sv
`timescale 1ns/100ps
`include "usb_test_defs.svh"

// One array serves both directions of endpoint 0
module ep0_shared_ram (
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic [`EP0_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [`EP0_AW-1:0] cpu_addr,
  output logic [7:0] cpu_data,
  input wire logic [`EP0_AW-1:0] tx_addr,
  output logic [7:0] tx_data
);

  logic [7:0] mem [0:`EP0_DEPTH-1];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign cpu_data = mem[cpu_addr];
  assign tx_data = mem[tx_addr];

endmodule : ep0_shared_ram

// ### rtl/usb_crc16_acc.sv
`timescale 1ns/100ps
`include "usb_test_defs.svh"

// Data CRC, bytes taken least significant bit first
module usb_crc16_acc (
  input wire logic aclk,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc_r
);

  logic [15:0] crc_nxt;

  always_comb begin
    crc_nxt = crc_r;
    for (int i = 0; i < 8; i++) begin
      if (crc_nxt[0] ^ din[i]) begin
        crc_nxt = (crc_nxt >> 1) ^ `CRC_POLY_REFL;
      end else begin
        crc_nxt = crc_nxt >> 1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      crc_r <= `CRC_INIT;
    end else if (en) begin
      crc_r <= crc_nxt;
    end
  end

endmodule : usb_crc16_acc

// ### rtl/usb_test_mode_ctrl.sv
`timescale 1ns/100ps
`include "usb_test_defs.svh"

// How it works
// - Test-packet mode resends the loaded endpoint 0 packet endlessly.
// - Writing 08h to the test select register enters test-packet mode.
// - Each test packet goes out as DATA0 PID, payload, then CRC.
// - Endpoint 0 transmit and receive share one 64-byte RAM.
// - Writing 40h copies CPU byte pointer to USB pointer, clears CPU one.
// - Then tx ready clears, rx ready sets, endpoint 0 interrupt raised.
// - Writing 80h forces host; ID, line state and disconnect ignored.
// - In forced host the disconnect level reads on the B-role bit.
// - Forced host follows the session bit, ignoring device disconnects.
// - Forced host speed comes from the two override bits.
// - Soft reset bit clears all controller registers, then self-clears.
// - Processor software resets do not disturb this controller.
// - Hardware reset returns every register to its default.
module usb_test_mode_ctrl
  import usb_test_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic role_id_input,
  input wire logic [1:0] bus_line_condition,
  input wire logic host_disconnect_input,
  output logic host_mode,
  output logic [1:0] speed_sel,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic controller_irq
);

  // --------------------------------------------------------------
  // Bus channel state, cleared only by the reset pin
  // --------------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_held_r, w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // --------------------------------------------------------------
  // Controller registers, cleared by reset pin or soft reset
  // --------------------------------------------------------------
  logic soft_rst_r;
  logic [7:0] test_select_reg_r;
  logic transmit_packet_ready_r, receive_packet_ready_r;
  logic session_r, host_mode_r;
  logic [1:0] speed_r;
  logic [`PTR_W-1:0] cpu_ptr_r, usb_ptr_r, rd_ptr_r, tx_idx_r;
  logic [`IRQ_W-1:0] irq_status_r, irq_mask_r;
  logic irq_r;
  tx_state_t tx_state_r;
  logic tx_valid_r, tx_last_r;
  logic [7:0] tx_data_r;

  // Bus-side reset is never touched by the soft reset, so a write
  // that sets it still completes its response.
  wire ctrl_rst = !aresetn || soft_rst_r;

  // --------------------------------------------------------------
  // Write and read decode
  // --------------------------------------------------------------
  wire wr_do = aw_held_r && w_held_r && !bvalid_r;
  wire wr_lane = w_strb_r[0];
  wire [7:0] wb = w_data_r[7:0];
  wire wr_ctrl = wr_do && wr_lane && aw_addr_r == `OFF_GLOBAL_CTRL;
  wire wr_test = wr_do && wr_lane && aw_addr_r == `OFF_TEST_SELECT;
  wire wr_csr = wr_do && wr_lane && aw_addr_r == `OFF_EP0_CSR;
  wire wr_dev = wr_do && wr_lane && aw_addr_r == `OFF_DEV_CTRL;
  wire wr_fifo = wr_do && wr_lane && aw_addr_r == `OFF_EP0_FIFO;
  wire wr_ists = wr_do && wr_lane && aw_addr_r == `OFF_IRQ_STATUS;
  wire wr_imsk = wr_do && wr_lane && aw_addr_r == `OFF_IRQ_MASK;
  wire wr_hit = wr_ctrl || wr_test || wr_csr || wr_dev || wr_fifo ||
                wr_ists || wr_imsk || aw_addr_r == `OFF_EP0_COUNT;

  wire rd_do = arvalid && arready_r;
  wire rd_fifo = rd_do && araddr == `OFF_EP0_FIFO;

  wire fifo_access_go = wr_test && wb[`BIT_FIFO_ACCESS];
  wire force_host = test_select_reg_r[`BIT_FORCE_HOST];
  wire pkt_mode = test_select_reg_r[`BIT_TEST_PACKET];

  // --------------------------------------------------------------
  // Shared endpoint 0 RAM and CRC
  // --------------------------------------------------------------
  wire cpu_wr = wr_fifo && cpu_ptr_r < `PTR_W'(`EP0_DEPTH);
  logic [7:0] ram_cpu_q, ram_tx_q;
  logic [15:0] crc_r;

  ep0_shared_ram u_ram (
    .aclk(aclk),
    .wr_en(cpu_wr),
    .wr_addr(cpu_ptr_r[`EP0_AW-1:0]),
    .wr_data(wb),
    .cpu_addr(rd_ptr_r[`EP0_AW-1:0]),
    .cpu_data(ram_cpu_q),
    .tx_addr(tx_idx_r[`EP0_AW-1:0]),
    .tx_data(ram_tx_q)
  );

  // --------------------------------------------------------------
  // Test packet transmitter
  // --------------------------------------------------------------
  wire tx_adv = !tx_valid_r || tx_ready;
  wire pkt_go = pkt_mode && transmit_packet_ready_r && cpu_ptr_r != '0;
  wire load_pid = tx_adv && pkt_go &&
                  (tx_state_r == TX_IDLE || tx_state_r == TX_CRC_HI);
  wire load_data = tx_adv && tx_idx_r != cpu_ptr_r &&
                   (tx_state_r == TX_PID || tx_state_r == TX_DATA);
  wire load_crc_lo = tx_adv && tx_state_r == TX_DATA &&
                     tx_idx_r == cpu_ptr_r;
  wire round_done = tx_valid_r && tx_ready && tx_state_r == TX_CRC_HI;

  usb_crc16_acc u_crc (
    .aclk(aclk),
    .clr(ctrl_rst || load_pid),
    .en(load_data),
    .din(ram_tx_q),
    .crc_r(crc_r)
  );

  always_ff @(posedge aclk) begin
    if (ctrl_rst) begin
      tx_state_r <= TX_IDLE;
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_idx_r <= '0;
    end else if (load_pid) begin
      tx_state_r <= TX_PID;
      tx_valid_r <= 1'b1;
      tx_last_r <= 1'b0;
      tx_data_r <= `PID_DATA0;
      tx_idx_r <= '0;
    end else if (load_data) begin
      tx_state_r <= TX_DATA;
      tx_data_r <= ram_tx_q;
      tx_idx_r <= tx_idx_r + `PTR_W'(1);
    end else if (load_crc_lo) begin
      tx_state_r <= TX_CRC_LO;
      tx_data_r <= ~crc_r[7:0];
    end else if (tx_adv && tx_state_r == TX_CRC_LO) begin
      tx_state_r <= TX_CRC_HI;
      tx_data_r <= ~crc_r[15:8];
      tx_last_r <= 1'b1;
    end else if (round_done) begin
      tx_state_r <= TX_IDLE;
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Test select, endpoint 0 status and pointers
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (ctrl_rst) begin
      soft_rst_r <= 1'b0;
      test_select_reg_r <= 8'h00;
    end else begin
      soft_rst_r <= wr_ctrl && wb[`BIT_SOFT_RESET];
      if (wr_test) begin
        test_select_reg_r <= wb;
      end
    end
  end

  wire tx_rdy_set = wr_csr && wb[`BIT_TX_READY];
  wire rx_serviced = wr_csr && wb[`BIT_RX_SERVICED];

  always_ff @(posedge aclk) begin
    if (ctrl_rst) begin
      transmit_packet_ready_r <= 1'b0;
      receive_packet_ready_r <= 1'b0;
      cpu_ptr_r <= '0;
      usb_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (fifo_access_go) begin
      usb_ptr_r <= cpu_ptr_r;
      cpu_ptr_r <= '0;
      rd_ptr_r <= '0;
      transmit_packet_ready_r <= 1'b0;
      receive_packet_ready_r <= 1'b1;
    end else begin
      if (tx_rdy_set) begin
        transmit_packet_ready_r <= 1'b1;
      end
      if (rx_serviced) begin
        receive_packet_ready_r <= 1'b0;
        usb_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else if (rd_fifo && rd_ptr_r < usb_ptr_r) begin
        rd_ptr_r <= rd_ptr_r + `PTR_W'(1);
      end
      if (cpu_wr) begin
        cpu_ptr_r <= cpu_ptr_r + `PTR_W'(1);
      end
    end
  end

  // --------------------------------------------------------------
  // Role and speed
  // --------------------------------------------------------------
  wire normal_host = session_r && !role_id_input &&
                     !host_disconnect_input && bus_line_condition != 2'h3;
  wire host_mode_nxt = force_host ? session_r : normal_host;
  wire b_role = force_host ? host_disconnect_input : role_id_input;
  wire [1:0] speed_nxt =
    !force_host ? `SPEED_HS :
    test_select_reg_r[`BIT_HS_OVERRIDE] ? `SPEED_HS :
    test_select_reg_r[`BIT_FS_OVERRIDE] ? `SPEED_FS : `SPEED_LS;

  always_ff @(posedge aclk) begin
    if (ctrl_rst) begin
      session_r <= 1'b0;
      host_mode_r <= 1'b0;
      speed_r <= `SPEED_HS;
    end else begin
      if (wr_dev) begin
        session_r <= wb[`BIT_SESSION];
      end
      host_mode_r <= host_mode_nxt;
      speed_r <= speed_nxt;
    end
  end

  // --------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // --------------------------------------------------------------
  wire [`IRQ_W-1:0] irq_set = {round_done, fifo_access_go};
  wire [`IRQ_W-1:0] irq_clr = wr_ists ? wb[`IRQ_W-1:0] : '0;
  wire [`IRQ_W-1:0] irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

  always_ff @(posedge aclk) begin
    if (ctrl_rst) begin
      irq_status_r <= '0;
      irq_mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      if (wr_imsk) begin
        irq_mask_r <= wb[`IRQ_W-1:0];
      end
      irq_r <= |(irq_status_nxt & (wr_imsk ? wb[`IRQ_W-1:0] : irq_mask_r));
    end
  end

  // --------------------------------------------------------------
  // Read data selection
  // --------------------------------------------------------------
  wire [7:0] csr_rd = {1'b0, 5'h00, transmit_packet_ready_r,
                       receive_packet_ready_r};
  wire [7:0] dev_rd = {b_role, 4'h0, host_mode_r, 1'b0, session_r};
  wire rd_hit = araddr == `OFF_GLOBAL_CTRL || araddr == `OFF_TEST_SELECT ||
                araddr == `OFF_EP0_CSR || araddr == `OFF_DEV_CTRL ||
                araddr == `OFF_EP0_FIFO || araddr == `OFF_EP0_COUNT ||
                araddr == `OFF_IRQ_STATUS || araddr == `OFF_IRQ_MASK;
  wire [7:0] rd_byte =
    araddr == `OFF_GLOBAL_CTRL ? {7'h00, soft_rst_r} :
    araddr == `OFF_TEST_SELECT ? test_select_reg_r :
    araddr == `OFF_EP0_CSR ? csr_rd :
    araddr == `OFF_DEV_CTRL ? dev_rd :
    araddr == `OFF_EP0_FIFO ? (rd_ptr_r < usb_ptr_r ? ram_cpu_q : 8'h00) :
    araddr == `OFF_EP0_COUNT ? {1'b0, usb_ptr_r} :
    araddr == `OFF_IRQ_STATUS ? {6'h00, irq_status_r} :
    araddr == `OFF_IRQ_MASK ? {6'h00, irq_mask_r} : 8'h00;

  // --------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else if (rd_do) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign host_mode = host_mode_r;
  assign speed_sel = speed_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign tx_last = tx_last_r;
  assign controller_irq = irq_r;

endmodule : usb_test_mode_ctrl

// ### verification/usb_far_end.sv
`timescale 1ns/100ps

// ------------------------------------------
// Far-side byte sink, prompt or stalling
// ------------------------------------------
module usb_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  output logic tx_ready
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
    end else if (slow) begin
      tx_ready <= 1'($urandom_range(0, 1));
    end else begin
      tx_ready <= 1'b1;
    end
  end
endmodule : usb_far_end

// ### verification/usb_test_mode_assertions.sv
`timescale 1ns/100ps
`include "usb_test_defs.svh"

module usb_test_mode_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_answer;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write unanswered");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_w_blocked;
    bvalid |-> !awready && !wready;
  endproperty
  a_w_blocked: assert property (p_w_blocked) else $error("write reopened");
  property p_rd_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && !arready;
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_unmapped;
    awvalid && awready && wvalid && wready && awaddr > 8'h1C
      |-> ##2 bvalid && bresp == `RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped okay");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("byte dropped");
  property p_round_gap;
    tx_valid && tx_ready && tx_last
      |=> !tx_last && (!tx_valid || tx_data == `PID_DATA0);
  endproperty
  a_round_gap: assert property (p_round_gap) else $error("no repeat");
  property p_pid_first;
    $rose(tx_valid) |-> tx_data == `PID_DATA0;
  endproperty
  a_pid_first: assert property (p_pid_first) else $error("no pid");
endmodule : usb_test_mode_checker

bind usb_test_mode_ctrl usb_test_mode_checker chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last)
);

// ### verification/test_usb_test_mode_and_reset.sv
`timescale 1ns/100ps
`include "usb_test_defs.svh"

module test_usb_test_mode_and_reset;
  import usb_test_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, l;
  logic awready, wready, bvalid, arready, rvalid, host_mode, tx_valid;
  logic role_id_input, host_disconnect_input, tx_ready, tx_last;
  logic controller_irq;
  logic [7:0] awaddr, araddr, tx_data, d, e, q[$];
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, speed_sel, bus_line_condition;
  logic [15:0] crc;
  logic [7:0] ts_tab [4] = '{8'h90, 8'hA0, 8'h80, 8'hB0};
  logic [1:0] sp_tab [4] = '{`SPEED_HS, `SPEED_FS, `SPEED_LS, `SPEED_HS};
  int err_count, check_count, n, r, len;

  usb_test_mode_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .role_id_input(role_id_input), .bus_line_condition(bus_line_condition),
    .host_disconnect_input(host_disconnect_input), .host_mode(host_mode),
    .speed_sel(speed_sel), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .controller_irq(controller_irq));
  usb_far_end far (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .tx_ready(tx_ready));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic limit_hit(input int k);
    if (k >= 200) begin
      err_count++;
      test_done;
    end
  endtask : limit_hit

  task automatic wr(input logic [7:0] a, v, input logic [1:0] er = 2'h0);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200 && !(bvalid && bready); k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    limit_hit(k);
    chk("bresp", bresp, er);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v,
                    input logic [1:0] er = 2'h0);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200 && !(rvalid && rready); k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    limit_hit(k);
    chk("rresp", rresp, er);
    chk("rdata_upper", rdata[31:8], 24'h0);
    v = rdata[7:0];
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, exp);
    logic [7:0] v;
    rd(a, v);
    chk("register", v, exp);
  endtask : rchk

  task automatic take(output logic [7:0] v, output logic lst);
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      if (tx_valid && tx_ready) break;
    end
    limit_hit(k);
    v = tx_data;
    lst = tx_last;
  endtask : take

  // ------------------------------------------
  // Expected test packet and its check code
  // ------------------------------------------
  function automatic logic [7:0] pat(input int i);
    if (i < 9) return 8'h00;
    if (i < 17) return 8'hAA;
    if (i < 25) return 8'hEE;
    if (i == 25) return 8'hFE;
    if (i < 37) return 8'hFF;
    if (i < 44) return 8'hFF ^ (8'h80 >> (i - 37));
    if (i == 44) return 8'hFC;
    if (i == 45 || i == 52) return 8'h7E;
    return 8'hFF ^ (8'h80 >> (i - 45));
  endfunction : pat

  function automatic logic [15:0] crc16(input int cnt);
    logic [15:0] c;
    logic [7:0] p;
    c = `CRC_INIT;
    for (int i = 0; i < cnt; i++) begin
      p = pat(i);
      for (int b = 0; b < 8; b++) begin
        c = (c[0] ^ p[b]) ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc16

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, role_id_input, host_disconnect_input} = '0;
    bus_line_condition = 2'h0;
    wstrb = 4'hF;
    n = $urandom(32'hE677);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (n = 0; n < 32; n += 4) rchk(n[7:0], 8'h00);
    rd(8'h20, d, `RESP_SLVERR);
    chk("unmapped", d, 8'h00);
    wr(8'h24, 8'hFF, `RESP_SLVERR);
    // No session is started during the loopback runs
    for (r = 0; r < 2; r++) begin
      len = (r == 0) ? 66 : $urandom_range(1, 63);
      q.delete();
      repeat (len) begin
        d = 8'($urandom);
        q.push_back(d);
        wr(`OFF_EP0_FIFO, d);
      end
      len = (len > 64) ? 64 : len;
      wr(`OFF_EP0_CSR, 8'h02);
      wr(`OFF_TEST_SELECT, 8'h40);
      rchk(`OFF_EP0_CSR, 8'h01);
      rchk(`OFF_EP0_COUNT, len[7:0]);
      rchk(`OFF_IRQ_STATUS, 8'h01);
      chk("irq_masked", controller_irq, 1'b0);
      wr(`OFF_IRQ_MASK, 8'h01);
      repeat (2) @(posedge aclk);
      chk("irq", controller_irq, 1'b1);
      for (n = 0; n < len; n++) begin
        rd(`OFF_EP0_FIFO, d);
        chk("loopback", d, q[n]);
      end
      wr(`OFF_EP0_CSR, 8'h40);
      rchk(`OFF_EP0_CSR, 8'h00);
      wr(`OFF_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge aclk);
      chk("irq_clear", controller_irq, 1'b0);
      wr(`OFF_IRQ_MASK, 8'h00);
      wr(`OFF_TEST_SELECT, 8'h00);
    end
    role_id_input <= 1'b1;
    wr(`OFF_TEST_SELECT, 8'h90);
    wr(`OFF_DEV_CTRL, 8'h01);
    for (n = 0; n < 4; n++) begin
      bus_line_condition <= 2'($urandom);
      host_disconnect_input <= n[0];
      wr(`OFF_TEST_SELECT, ts_tab[n]);
      repeat (3) @(posedge aclk);
      chk("host_mode", host_mode, 1'b1);
      chk("speed", speed_sel, sp_tab[n]);
      rchk(`OFF_DEV_CTRL, {n[0], 7'h05});
    end
    wr(`OFF_DEV_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk("host_off", host_mode, 1'b0);
    wr(`OFF_TEST_SELECT, 8'h00);
    wr(`OFF_DEV_CTRL, 8'h01);
    repeat (3) @(posedge aclk);
    chk("host_blocked", host_mode, 1'b0);
    role_id_input <= 1'b0;
    host_disconnect_input <= 1'b0;
    bus_line_condition <= 2'h3;
    repeat (3) @(posedge aclk);
    chk("host_line", host_mode, 1'b0);
    bus_line_condition <= 2'h0;
    repeat (3) @(posedge aclk);
    chk("host_norm", host_mode, 1'b1);
    for (n = 0; n < 53; n++) wr(`OFF_EP0_FIFO, pat(n));
    wr(`OFF_IRQ_MASK, 8'h02);
    wr(`OFF_TEST_SELECT, 8'h08);
    slow <= 1'b1;
    wr(`OFF_EP0_CSR, 8'h02);
    crc = crc16(53);
    for (r = 0; r < 2; r++) begin
      for (n = 0; n < 56; n++) begin
        take(d, l);
        e = (n == 0) ? `PID_DATA0 : (n < 54) ? pat(n - 1) : crc[7:0];
        e = (n == 55) ? crc[15:8] : e;
        chk("tx_byte", d, e);
        chk("tx_last", l, n == 55);
      end
    end
    chk("irq_round", controller_irq, 1'b1);
    wr(`OFF_TEST_SELECT, 8'h00);
    repeat (200) @(posedge aclk);
    chk("tx_stop", tx_valid, 1'b0);
    wr(`OFF_TEST_SELECT, 8'h80);
    wr(`OFF_GLOBAL_CTRL, 8'h01);
    rchk(`OFF_GLOBAL_CTRL, 8'h00);
    rchk(`OFF_TEST_SELECT, 8'h00);
    rchk(`OFF_IRQ_MASK, 8'h00);
    rchk(`OFF_IRQ_STATUS, 8'h00);
    // Low lane disabled: the write has no effect
    wstrb <= 4'h0;
    wr(`OFF_IRQ_MASK, 8'h03, `RESP_SLVERR);
    wstrb <= 4'hF;
    rchk(`OFF_IRQ_MASK, 8'h00);
    wr(`OFF_TEST_SELECT, 8'h20);
    repeat (3) @(posedge aclk);
    chk("speed_norm", speed_sel, `SPEED_HS);
    wr(`OFF_IRQ_MASK, 8'h03);
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`OFF_TEST_SELECT, 8'h00);
    rchk(`OFF_IRQ_MASK, 8'h00);
    test_done;
  end
endmodule : test_usb_test_mode_and_reset
